// *** sfks_pkg.sv ***
package sfks_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int ROOT_BITS = 256;
	localparam int WORD_BITS = 32;
	localparam int ROOT_WORDS = ROOT_BITS / WORD_BITS;
	localparam int KEY_MIN_BITS = 64;
	localparam int KEY_MAX_BITS = 4096;
	localparam int KEY_MIN_WORDS = KEY_MIN_BITS / WORD_BITS;
	localparam int KEY_MAX_WORDS = KEY_MAX_BITS / WORD_BITS;
	localparam int INDEX_BITS = 4;
	localparam int LEN_BITS = 8;
	localparam int CNT_BITS = 8;

	// ****************************************
	// Key code header word layout
	// ****************************************
	localparam int HDR_INDEX_POS = 28;
	localparam int HDR_LEN_POS = 20;
	localparam int HDR_CHECK_BITS = 20;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [CNT_BITS-1:0] CNT_RESET = 8'h00;
	localparam logic [INDEX_BITS-1:0] INDEX_RESET = 4'h0;
	localparam logic [LEN_BITS-1:0] LEN_RESET = 8'h00;
	localparam logic [WORD_BITS-1:0] WORD_RESET = 32'h00000000;

	// ****************************************
	// Commands and states
	// ****************************************
	typedef enum logic [2:0] {
		SFKS_CMD_ENROLL = 3'h0,
		SFKS_CMD_START = 3'h1,
		SFKS_CMD_SET_KEY = 3'h2,
		SFKS_CMD_GEN_KEY = 3'h3,
		SFKS_CMD_GET_KEY = 3'h4
	} sfks_cmd_type;

	typedef enum {
		SFKS_IDLE,
		SFKS_ENROLL,
		SFKS_START,
		SFKS_WRAP_HDR,
		SFKS_WRAP_DATA,
		SFKS_UNWRAP_HDR,
		SFKS_UNWRAP_DATA
	} sfks_state_type;

endpackage

// *** sfks_mix.sv ***
`timescale 1ns/1ps
`default_nettype none

module sfks_mix #(
	parameter int ROOT_W = 256,
	parameter int WORD_W = 32,
	parameter int SEL_W = 8
) (
	input wire logic [ROOT_W-1:0] root,
	input wire logic [ROOT_W-1:0] fingerprint,
	input wire logic [SEL_W-1:0] sel,
	output logic [WORD_W-1:0] mask,
	output logic [WORD_W-1:0] fp_word,
	output logic [WORD_W-1:0] fold
);
	localparam int NW = ROOT_W / WORD_W;
	localparam int NW_BITS = $clog2(NW);

	// The select must hold a word slot and still leave room in a word
	if (ROOT_W % WORD_W != 0 || NW < 2 || SEL_W >= WORD_W || SEL_W <= NW_BITS) begin
		$error("sfks_mix: unsupported widths");
	end

	logic [WORD_W-1:0] root_w [NW];
	logic [WORD_W-1:0] fp_w [NW];
	logic [WORD_W-1:0] acc [NW+1];
	logic [NW_BITS-1:0] slot;

	// ****************************************
	// Word slicing and folding
	// ****************************************
	assign acc[0] = '0;
	for (genvar i = 0; i < NW; i++) begin : g_word
		assign root_w[i] = root[i*WORD_W +: WORD_W];
		assign fp_w[i] = fingerprint[i*WORD_W +: WORD_W];
		assign acc[i+1] = acc[i] ^ {root_w[i][WORD_W-2:0], root_w[i][WORD_W-1]};
	end
	assign fold = acc[NW];

	// Position is mixed in so that repeated key words never share a mask
	assign slot = sel[NW_BITS-1:0];
	assign mask = root_w[slot] ^ {{(WORD_W-SEL_W){1'b0}}, sel} ^ {fold[WORD_W/2-1:0],
		fold[WORD_W-1:WORD_W/2]};
	assign fp_word = fp_w[slot];

endmodule

`default_nettype wire

// *** sfks_core.sv ***
`timescale 1ns/1ps
`default_nettype none

module sfks_core #(
	parameter int KEY_WORDS_MAX = sfks_pkg::KEY_MAX_WORDS
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [sfks_pkg::ROOT_BITS-1:0] fingerprint,
	input wire logic [sfks_pkg::WORD_BITS-1:0] rng_word,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [2:0] cmd_code,
	input wire logic [sfks_pkg::INDEX_BITS-1:0] cmd_index,
	input wire logic [sfks_pkg::LEN_BITS-1:0] cmd_len,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [sfks_pkg::WORD_BITS-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [sfks_pkg::WORD_BITS-1:0] out_data,
	output logic out_last,
	output logic hwkey_valid,
	input wire logic hwkey_ready,
	output logic [sfks_pkg::WORD_BITS-1:0] hwkey_data,
	output logic hwkey_last,
	output logic busy,
	output logic root_valid,
	output logic error
);
	import sfks_pkg::*;

	// Lengths are bounded by the package range of 2 to 128 words, not by the 8-bit counters
	if (KEY_WORDS_MAX < KEY_MIN_WORDS || KEY_WORDS_MAX > KEY_MAX_WORDS) begin : g_bad_len
		$error("sfks_core: KEY_WORDS_MAX out of range");
	end

	sfks_state_type state;
	logic [ROOT_BITS-1:0] root;
	logic [CNT_BITS-1:0] cnt;
	logic [INDEX_BITS-1:0] index;
	logic [LEN_BITS-1:0] len;
	logic [WORD_BITS-1:0] mask, fp_word, fold, hdr_check, next_word;
	logic gen, sw_full, hw_full, sw_free, hw_free, to_bus, step, last_word;
	logic hdr_ok, hdr_len_ok, cmd_take, len_ok, cmd_refused, root_phase, root_done;

	// ****************************************
	// Root and key masking
	// ****************************************
	sfks_mix #(
		.ROOT_W(ROOT_BITS),
		.WORD_W(WORD_BITS),
		.SEL_W(CNT_BITS)
	) u_mix (
		.root(root),
		.fingerprint(fingerprint),
		.sel(cnt),
		.mask(mask),
		.fp_word(fp_word),
		.fold(fold)
	);

	// ****************************************
	// Handshakes
	// ****************************************
	// One output word each side; a word moves on only when the slot is free
	assign sw_free = !sw_full || out_ready;
	assign hw_free = !hw_full || hwkey_ready;
	assign to_bus = (state == SFKS_UNWRAP_DATA) && (index == INDEX_RESET);
	assign last_word = (cnt == CNT_BITS'(len - 8'h01));
	assign hdr_check = {{(WORD_BITS-HDR_CHECK_BITS){1'b0}}, fold[HDR_CHECK_BITS-1:0]};
	assign hdr_ok = (in_data[HDR_CHECK_BITS-1:0] == hdr_check[HDR_CHECK_BITS-1:0]);
	assign hdr_len_ok = (in_data[HDR_LEN_POS +: LEN_BITS] >= LEN_BITS'(KEY_MIN_WORDS)) &&
		(in_data[HDR_LEN_POS +: LEN_BITS] <= LEN_BITS'(KEY_WORDS_MAX));
	assign len_ok = (cmd_len >= LEN_BITS'(KEY_MIN_WORDS)) &&
		(cmd_len <= LEN_BITS'(KEY_WORDS_MAX));
	assign cmd_ready = (state == SFKS_IDLE);
	assign cmd_take = cmd_valid && cmd_ready;
	assign busy = (state != SFKS_IDLE);
	assign root_phase = (state == SFKS_ENROLL) || (state == SFKS_START);
	assign root_done = step && root_phase && (cnt == CNT_BITS'(ROOT_WORDS));
	// Refused commands leave the machine idle and raise the error flag; index, len and gen still load
	assign cmd_refused = cmd_take && ((cmd_code > SFKS_CMD_GET_KEY) ||
		((cmd_code >= SFKS_CMD_SET_KEY) && !root_valid) ||
		((cmd_code == SFKS_CMD_SET_KEY || cmd_code == SFKS_CMD_GEN_KEY) && !len_ok));

	// Decide whether the current state moves a word this cycle
	always_comb begin
		in_ready = 1'b0;
		step = 1'b0;
		case (state)
			SFKS_ENROLL, SFKS_WRAP_HDR: begin
				step = sw_free;
			end
			SFKS_START, SFKS_UNWRAP_HDR: begin
				in_ready = 1'b1;
				step = in_valid;
			end
			SFKS_WRAP_DATA: begin
				in_ready = !gen && sw_free;
				step = sw_free && (gen || in_valid);
			end
			SFKS_UNWRAP_DATA: begin
				in_ready = to_bus ? hw_free : sw_free;
				step = in_valid && in_ready;
			end
			default: step = 1'b0;
		endcase
	end

	// Word that leaves in the current step
	always_comb begin
		next_word = WORD_RESET;
		case (state)
			SFKS_ENROLL: begin
				next_word = (cnt < CNT_BITS'(ROOT_WORDS)) ? (fp_word ^ rng_word) : fold;
			end
			SFKS_WRAP_HDR: begin
				next_word = (WORD_BITS'(index) << HDR_INDEX_POS) |
					(WORD_BITS'(len) << HDR_LEN_POS) | hdr_check;
			end
			SFKS_WRAP_DATA: begin
				next_word = (gen ? rng_word : in_data) ^ mask;
			end
			SFKS_UNWRAP_DATA: begin
				next_word = in_data ^ mask;
			end
			default: next_word = WORD_RESET;
		endcase
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state <= SFKS_IDLE;
			cnt <= CNT_RESET;
			index <= INDEX_RESET;
			len <= LEN_RESET;
			gen <= 1'b0;
		end else begin
			case (state)
				SFKS_IDLE: begin
					cnt <= CNT_RESET;
					if (cmd_take) begin
						index <= cmd_index;
						len <= cmd_len;
						gen <= (cmd_code == SFKS_CMD_GEN_KEY);
					end
					if (cmd_take && !cmd_refused) begin
						case (cmd_code)
							SFKS_CMD_ENROLL: state <= SFKS_ENROLL;
							SFKS_CMD_START: state <= SFKS_START;
							SFKS_CMD_GET_KEY: state <= SFKS_UNWRAP_HDR;
							default: state <= SFKS_WRAP_HDR; // Set or generate with a valid root
						endcase
					end
				end
				SFKS_WRAP_HDR: begin
					if (step) begin
						state <= SFKS_WRAP_DATA;
					end
				end
				SFKS_UNWRAP_HDR: begin
					if (step) begin
						index <= in_data[HDR_INDEX_POS +: INDEX_BITS];
						len <= in_data[HDR_LEN_POS +: LEN_BITS];
						// A foreign header ends the request before any key word exists
						if (hdr_ok && hdr_len_ok) begin
							state <= SFKS_UNWRAP_DATA;
						end else begin
							state <= SFKS_IDLE;
						end
					end
				end
				SFKS_ENROLL, SFKS_START, SFKS_WRAP_DATA, SFKS_UNWRAP_DATA: begin
					if (step) begin
						cnt <= cnt + 8'h01;
					end
					// Root phases end on their own count, key phases on the stated length
					if (root_done || (step && last_word && !root_phase)) begin
						state <= SFKS_IDLE;
					end
				end
				default: state <= SFKS_IDLE;
			endcase
		end
	end

	// ****************************************
	// Root key
	// ****************************************
	// Root is the only secret held; key words pass through unstored
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			root <= '0;
			root_valid <= 1'b0;
		end else begin
			if (cmd_take && (cmd_code == SFKS_CMD_ENROLL || cmd_code == SFKS_CMD_START)) begin
				root_valid <= 1'b0;
			end
			if (step && cnt < CNT_BITS'(ROOT_WORDS)) begin
				if (state == SFKS_ENROLL) begin
					root[cnt[2:0]*WORD_BITS +: WORD_BITS] <= rng_word;
				end else if (state == SFKS_START) begin
					root[cnt[2:0]*WORD_BITS +: WORD_BITS] <= fp_word ^ in_data;
				end
			end
			if (step && cnt == CNT_BITS'(ROOT_WORDS)) begin
				if (state == SFKS_ENROLL) begin
					root_valid <= 1'b1;
				end else if (state == SFKS_START) begin
					root_valid <= (in_data == fold);
				end
			end
		end
	end

	// ****************************************
	// Error flag
	// ****************************************
	// Set wins over the clear made by the next accepted command
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			error <= 1'b0;
		end else begin
			if (root_done && state == SFKS_START && in_data != fold) begin
				error <= 1'b1;
			end else if (state == SFKS_UNWRAP_HDR && step && !(hdr_ok && hdr_len_ok)) begin
				error <= 1'b1;
			end else if (cmd_refused) begin
				error <= 1'b1;
			end else if (cmd_take) begin
				error <= 1'b0;
			end
		end
	end

	// ****************************************
	// Output slots
	// ****************************************
	// Two separate data registers so a key word only ever sits on one port
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sw_full <= 1'b0;
			out_data <= WORD_RESET;
			out_last <= 1'b0;
		end else if (step && state != SFKS_START && state != SFKS_UNWRAP_HDR && !to_bus) begin
			sw_full <= 1'b1;
			out_data <= next_word;
			out_last <= (state == SFKS_ENROLL) ? (cnt == CNT_BITS'(ROOT_WORDS)) :
				((state != SFKS_WRAP_HDR) && last_word);
		end else if (out_ready) begin
			sw_full <= 1'b0;
			out_data <= WORD_RESET; // Clear after hand-off so nothing lingers
			out_last <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			hw_full <= 1'b0;
			hwkey_data <= WORD_RESET;
			hwkey_last <= 1'b0;
		end else if (step && to_bus) begin
			hw_full <= 1'b1;
			hwkey_data <= next_word;
			hwkey_last <= last_word;
		end else if (hwkey_ready) begin
			hw_full <= 1'b0;
			hwkey_data <= WORD_RESET;
			hwkey_last <= 1'b0;
		end
	end

	assign out_valid = sw_full;
	assign hwkey_valid = hw_full;

endmodule

`default_nettype wire

// *** sfks_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfks_asserts
	import sfks_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic [2:0] cmd_code,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [sfks_pkg::WORD_BITS-1:0] out_data,
	input wire logic hwkey_valid,
	input wire logic hwkey_ready,
	input wire logic [sfks_pkg::WORD_BITS-1:0] hwkey_data,
	input wire logic hwkey_last,
	input wire logic busy,
	input wire logic root_valid,
	input wire logic error
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// A key word never shows on both exits at once
	a_one_side: assert property (!(out_valid && hwkey_valid))
		else $error("both key outputs valid");
	a_hw_hold: assert property (hwkey_valid && !hwkey_ready |=> hwkey_valid && $stable(hwkey_data))
		else $error("key bus word dropped");
	a_sw_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("read word dropped");
	// Idle exits read zero so nothing leaks
	a_hw_quiet: assert property (!hwkey_valid |-> hwkey_data == WORD_RESET)
		else $error("key bus data while idle");
	a_sw_quiet: assert property (!out_valid |-> out_data == WORD_RESET)
		else $error("read data while idle");
	a_hw_last: assert property (hwkey_last |-> hwkey_valid)
		else $error("key bus last flag without word");
	a_err_quiet: assert property (error && !busy |-> !hwkey_valid)
		else $error("key bus active on error");
	a_bad_code: assert property (cmd_valid && cmd_ready && cmd_code > 3'h4 |=> error && !busy)
		else $error("unknown command not refused");
	a_enroll_go: assert property (cmd_valid && cmd_ready && cmd_code == 3'h0 |=> busy && !root_valid)
		else $error("enroll did not start");
	a_enroll_end: assert property (cmd_valid && cmd_ready && cmd_code == 3'h0 |-> ##[2:60] root_valid)
		else $error("enroll gave no root");
endmodule
bind sfks_core sfks_asserts u_chk (.*);
`default_nettype wire

// *** sfks_keysink.sv ***
`timescale 1ns/1ps
`default_nettype none
module sfks_keysink
	import sfks_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic slow,
	input wire logic hwkey_valid,
	input wire logic [sfks_pkg::WORD_BITS-1:0] hwkey_data,
	input wire logic hwkey_last,
	output logic hwkey_ready
);
	logic [WORD_BITS-1:0] q[$];
	int lasts = 0;
	// A busy cipher takes a word only every other cycle
	always_ff @(negedge sys_clk or negedge resetn) begin
		if (!resetn)
			hwkey_ready <= 1'b0;
		else
			hwkey_ready <= slow ? ~hwkey_ready : 1'b1;
	end
	// Words count only on a seen handshake
	always @(posedge sys_clk) begin
		if (resetn && hwkey_valid && hwkey_ready) begin
			q.push_back(hwkey_data);
			lasts += hwkey_last;
		end
	end
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	fail_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module testbench;
	import sfks_pkg::*;
	logic sys_clk = 1'b0, resetn = 1'b0, cmd_valid = 1'b0, in_valid = 1'b0;
	logic out_ready = 1'b1, slow = 1'b0;
	logic cmd_ready, in_ready, out_valid, out_last, hwkey_valid, hwkey_ready;
	logic hwkey_last, busy, root_valid, error;
	logic [2:0] cmd_code = 3'h0;
	logic [3:0] cmd_index = 4'h0;
	logic [7:0] cmd_len = 8'h00;
	logic [31:0] in_data = 32'h0, rng_word = 32'h1234ABCD, out_data, hwkey_data;
	logic [255:0] fingerprint = 256'h9E3779B97F4A7C15F39CC0605CEDC8341082276BF3A27251C6E1D4A25B8E0F31;
	logic [31:0] sq[$], ac[$], kc[$], kw[$];
	int fail_count = 0, samples_checked = 0, lasts = 0;
	sfks_core #(.KEY_WORDS_MAX(128)) uut (.*);
	sfks_keysink ks (.*);
	// Clock, moving random word and a read side that can stall
	always #50 sys_clk = ~sys_clk;
	always @(negedge sys_clk) begin
		rng_word <= {rng_word[30:0], rng_word[31] ^ rng_word[21]};
		out_ready <= slow ? ~out_ready : 1'b1;
	end
	always @(posedge sys_clk) begin
		if (out_valid && out_ready) begin
			sq.push_back(out_data);
			lasts += out_last;
		end
	end
	// ****************************************
	// Drivers
	// ****************************************
	task stop_test;
		if (fail_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task clr;
		sq.delete();
		ks.q.delete();
		lasts = 0;
		ks.lasts = 0;
	endtask
	task cmd(input logic [2:0] c, input logic [3:0] i, input logic [7:0] n);
		cmd_code = c;
		cmd_index = i;
		cmd_len = n;
		cmd_valid = 1'b1;
		@(negedge sys_clk);
		cmd_valid = 1'b0;
	endtask
	// Valid stays up between words so it never toggles in one step
	task feed(input logic [31:0] w[$]);
		foreach (w[i]) begin
			in_data = w[i];
			in_valid = 1'b1;
			// Ready is judged at the rising edge, where the core takes the word
			do
				@(posedge sys_clk);
			while (!in_ready);
			@(negedge sys_clk);
		end
		in_valid = 1'b0;
	endtask
	task idle;
		@(negedge sys_clk);
		while (busy || out_valid || hwkey_valid)
			@(negedge sys_clk);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task t_refuse(input logic [2:0] c, input logic [7:0] n);
		clr;
		cmd(c, 4'h3, n);
		idle;
		`CHK("refused err", 1'b1, error)
		`CHK("refused out", 0, sq.size())
	endtask
	task t_enroll;
		clr;
		cmd(3'h0, 4'h0, 8'h00);
		idle;
		ac = sq;
		`CHK("ac words", 9, sq.size())
		`CHK("ac last", 1, lasts)
		`CHK("root", 1'b1, root_valid)
	endtask
	task t_start(input logic bad);
		logic [31:0] w[$];
		w = ac;
		w[8] = w[8] ^ {31'h0, bad};
		clr;
		cmd(3'h1, 4'h0, 8'h00);
		feed(w);
		idle;
		`CHK("start err", bad, error)
		`CHK("start root", !bad, root_valid)
	endtask
	task t_wrap(input logic [3:0] idx, input logic [7:0] n, input logic gen);
		kw.delete();
		if (!gen)
			for (int i = 0; i < n; i++)
				kw.push_back(32'h5A3C0000 ^ 32'(i * 7));
		clr;
		cmd(gen ? 3'h3 : 3'h2, idx, n);
		feed(kw);
		idle;
		kc = sq;
		`CHK("code len", n + 1, sq.size())
		`CHK("code idx", idx, sq[0][31:28])
		`CHK("code last", 1, lasts)
		if (!gen)
			`CHK("masked", 1'b1, sq[1] !== kw[0])
	endtask
	task t_unwrap(input logic [3:0] idx, input logic [7:0] n);
		logic [31:0] got[$];
		clr;
		cmd(3'h4, 4'h0, 8'h00);
		feed(kc);
		idle;
		if (idx == 4'h0)
			got = ks.q;
		else
			got = sq;
		`CHK("sw words", idx == 4'h0 ? 0 : n, sq.size())
		`CHK("hw words", idx == 4'h0 ? n : 0, ks.q.size())
		foreach (kw[i])
			`CHK("key word", kw[i], got[i])
	endtask
	task t_badget;
		logic [31:0] h[$];
		// One header with a broken check field, one with a length below the minimum
		h.push_back(kc[0] ^ 32'h00000001);
		h.push_back({kc[0][31:28], 8'h01, kc[0][19:0]});
		foreach (h[i]) begin
			clr;
			cmd(3'h4, 4'h0, 8'h00);
			feed(h[i:i]);
			idle;
			`CHK("get err", 1'b1, error)
			`CHK("get out", 0, sq.size() + ks.q.size())
		end
	endtask
	// ****************************************
	// Main
	// ****************************************
	initial begin
		repeat (12) @(negedge sys_clk);
		resetn = 1'b1;
		t_refuse(3'h2, 8'h02);
		t_refuse(3'h4, 8'h00);
		t_enroll;
		t_start(1'b1);
		t_start(1'b0);
		t_refuse(3'h7, 8'h00);
		t_refuse(3'h2, 8'h01);
		t_refuse(3'h2, 8'h81);
		t_wrap(4'h0, 8'h02, 1'b0);
		t_unwrap(4'h0, 8'h02);
		slow = 1'b1;
		t_wrap(4'h5, 8'h80, 1'b0);
		t_unwrap(4'h5, 8'h80);
		t_wrap(4'h0, 8'h80, 1'b0);
		t_unwrap(4'h0, 8'h80);
		t_badget;
		t_wrap(4'hF, 8'h02, 1'b1);
		t_unwrap(4'hF, 8'h02);
		slow = 1'b0;
		resetn = 1'b0;
		@(negedge sys_clk);
		`CHK("reset root", 1'b0, root_valid)
		resetn = 1'b1;
		stop_test;
	end
	// Whole plan is just over a thousand cycles; 30000 means a hang
	initial begin
		#3000000;
		fail_count++;
		stop_test;
	end
endmodule
`default_nettype wire
